// ---- hdl/swc_top.sv ----
// Suspend and wake sequencer with AXI4-Lite register slave
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`include "swc_defines.svh"
`default_nettype none
module swc_top #(
	parameter int unsigned WAKE_PERIOD = 100000,
	parameter int unsigned EXT_SHORT = `SWC_EXT_SHORT_CYC,
	parameter int unsigned EXT_LONG = `SWC_EXT_LONG_CYC
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Response valid
	input wire logic s_axi_bready, // Response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read ready
	input wire logic kbd_serial_data, // D- line level
	input wire logic gpio_irq, // GPIO interrupt pending
	input wire logic spi_irq, // Serial slave interrupt pending
	input wire logic other_irq, // Other pending interrupts
	input wire logic osc_stable, // External oscillator stable
	input wire logic insn_done, // Processor finished one instruction
	output logic cpu_run, // Processor may execute
	output logic irq_hold, // Hold off interrupt service
	output logic osc_int_en, // Internal oscillator on
	output logic osc_ext_en, // External oscillator on
	output logic timer_en, // Free-running timer on
	output logic wdt_en, // Watchdog on
	output logic wake_irq, // Wake-timer interrupt pending
	output logic irq // Summary interrupt
);
	////////////////////////////////////////////////////////////////////
	typedef struct packed {
		swc_pkg::swc_state_e st;
		swc_pkg::swc_cnt_t cnt;
		logic [20:0] wcnt;
		logic [7:0] psc;
		logic [1:0] clk;
		logic [3:0] ien;
		logic [2:0] evst;
		logic [2:0] evmask;
		logic wake_pend;
		logic wlatch;
		logic aw, w, bv, rv;
		logic ws;
		logic [7:0] awa;
		logic [31:0] wd;
		logic [1:0] bresp, rresp;
		logic [31:0] rd;
		logic run, hold, oi, oe, ten, irq;
	} swc_state_s;

	swc_state_s q, d;

	////////////////////////////////////////////////////////////////////
	function automatic logic ofs_ok(input logic [7:0] a);
		ofs_ok = a == `SWC_PSC_OFS || a == `SWC_CLK_OFS ||
			a == `SWC_STAT_OFS || a == `SWC_CLR_OFS ||
			a == `SWC_IEN_OFS || a == `SWC_IPEND_OFS;
	endfunction

	logic [3:0] pend;
	logic wake_cond;
	logic do_wr;
	logic [2:0] ev;
	swc_pkg::swc_cnt_t ext_dly;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		pend = {other_irq, spi_irq, q.wake_pend, gpio_irq};
		// Enable-sense bit deliberately not consulted
		wake_cond = |(pend & q.ien) || !kbd_serial_data;
		ext_dly = q.clk[`SWC_CLK_LONG] ? swc_pkg::swc_cnt_t'(EXT_LONG)
			: swc_pkg::swc_cnt_t'(EXT_SHORT);
		do_wr = q.aw && q.w && !q.bv;
		ev = 3'h0;
		d = q;
		if (s_axi_awvalid && !q.aw) begin
			d.aw = 1'b1;
			d.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w) begin
			d.w = 1'b1;
			d.wd = s_axi_wdata;
			d.ws = s_axi_wstrb[0];
		end
		// Wake timer: independent of suspend; disable resets it
		if (!q.ien[`SWC_IRQ_WAKE]) begin
			d.wcnt = 21'h0;
			d.wake_pend = 1'b0;
		end else if (q.wcnt >= 21'(WAKE_PERIOD - 1)) begin
			d.wcnt = 21'h0;
			d.wake_pend = 1'b1;
		end else begin
			d.wcnt = q.wcnt + 21'h1;
		end
		// Clocked latch: a wake shorter than one period can be missed
		if (q.st == swc_pkg::SWC_SUSP && wake_cond)
			d.wlatch = 1'b1;
		if (q.cnt != '0)
			d.cnt = q.cnt - 21'h1;
		case (q.st)
		swc_pkg::SWC_RUN: begin
			d.run = q.psc[`SWC_PSC_RUN];
			d.hold = 1'b0;
			d.oi = !q.clk[`SWC_CLK_EXT];
			d.oe = q.clk[`SWC_CLK_EXT];
			d.ten = 1'b1;
			if (q.psc[`SWC_PSC_SUSP]) begin
				// Enter even with a wake already present
				d.st = swc_pkg::SWC_SUSP;
				d.wlatch = 1'b0;
				d.run = 1'b0;
				d.oi = 1'b0;
				d.oe = 1'b0;
				d.ten = 1'b0;
				ev[`SWC_EV_ENTER] = 1'b1;
			end
		end
		swc_pkg::SWC_SUSP: begin
			// Resume only while run bit stays set
			if (q.wlatch && q.psc[`SWC_PSC_RUN]) begin
				d.st = swc_pkg::SWC_START;
				ev[`SWC_EV_WAKE] = 1'b1;
				if (q.clk[`SWC_CLK_EXT]) begin
					d.oe = 1'b1;
				end else begin
					d.oi = 1'b1;
					d.cnt = swc_pkg::swc_cnt_t'(`SWC_INT_START_CYC);
				end
			end
		end
		swc_pkg::SWC_START: begin
			if (q.clk[`SWC_CLK_EXT] ? osc_stable : q.cnt == '0) begin
				d.st = swc_pkg::SWC_DELAY;
				d.cnt = q.clk[`SWC_CLK_EXT] ? ext_dly
					: swc_pkg::swc_cnt_t'(`SWC_INT_DLY_CYC);
			end
		end
		swc_pkg::SWC_DELAY: begin
			if (q.cnt == '0) begin
				d.st = swc_pkg::SWC_FIRST;
				d.psc[`SWC_PSC_SUSP] = 1'b0;
				d.run = 1'b1;
				d.hold = 1'b1;
				d.ten = 1'b1;
				d.wlatch = 1'b0;
				ev[`SWC_EV_RESUME] = 1'b1;
			end
		end
		swc_pkg::SWC_FIRST: begin
			// Interrupts wait for the post-suspend instruction
			if (insn_done) begin
				d.st = swc_pkg::SWC_RUN;
				d.hold = 1'b0;
			end
		end
		default: d.st = swc_pkg::SWC_RUN;
		endcase
		if (do_wr) begin
			d.aw = 1'b0;
			d.w = 1'b0;
			d.bv = 1'b1;
			d.bresp = ofs_ok(q.awa) ? 2'h0 : 2'h2;
			// Only byte lane 0 holds register bits
			if (q.ws) begin
				case (q.awa)
				`SWC_PSC_OFS: d.psc = q.wd[7:0];
				`SWC_CLK_OFS: d.clk = q.wd[1:0];
				`SWC_IEN_OFS: begin
					d.evmask = q.wd[6:4];
					d.ien = q.wd[3:0];
				end
				default: ;
				endcase
			end
		end
		if (q.bv && s_axi_bready)
			d.bv = 1'b0;
		if (s_axi_arvalid && !q.rv) begin
			d.rv = 1'b1;
			d.rresp = ofs_ok(s_axi_araddr) ? 2'h0 : 2'h2;
			case (s_axi_araddr)
			`SWC_PSC_OFS: d.rd = {24'h0, q.psc};
			`SWC_CLK_OFS: d.rd = {30'h0, q.clk};
			`SWC_STAT_OFS: d.rd = {29'h0, q.evst};
			`SWC_IEN_OFS: d.rd = {25'h0, q.evmask, q.ien};
			`SWC_IPEND_OFS: d.rd = {27'h0, q.st == swc_pkg::SWC_SUSP, pend};
			default: d.rd = 32'h0;
			endcase
		end else if (q.rv && s_axi_rready) begin
			d.rv = 1'b0;
		end
		// Set wins over clear
		d.evst = (q.evst & ~(do_wr && q.ws && q.awa == `SWC_CLR_OFS ?
			q.wd[2:0] : 3'h0)) | ev;
		d.irq = |(d.evst & d.evmask);
	end

	////////////////////////////////////////////////////////////////////
	// Reset sets the run bit but clears run, so the processor runs from the second cycle after reset, as after power-up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.psc <= `SWC_PSC_RST;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sequencer checks; one clock, so one default clocking serves all
	default clocking cb_main @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Firmware asks to sleep while running
	sequence s_enter_req;
		q.st == swc_pkg::SWC_RUN && q.psc[`SWC_PSC_SUSP];
	endsequence

	// Everything that must be dark in suspend
	sequence s_all_off;
		!cpu_run && !osc_int_en && !osc_ext_en && !timer_en && !wdt_en;
	endsequence

	// A latched wake with the run bit set
	sequence s_wake_req;
		q.st == swc_pkg::SWC_SUSP && q.wlatch && q.psc[`SWC_PSC_RUN];
	endsequence

	// One oscillator powered, waiting for it to settle
	sequence s_clock_up;
		q.st == swc_pkg::SWC_START && (osc_int_en || osc_ext_en);
	endsequence

	// Resume delay has run out
	sequence s_delay_done;
		q.st == swc_pkg::SWC_DELAY && q.cnt == '0;
	endsequence

	// Processor released, interrupts still held back
	sequence s_first_insn;
		q.st == swc_pkg::SWC_FIRST && cpu_run && irq_hold;
	endsequence

	a_suspend_entry: assert property (s_enter_req |=> s_all_off)
		else $error("suspend entry left a clock or the processor on");

	a_entry_with_wake: assert property (
		q.st == swc_pkg::SWC_RUN && q.psc[`SWC_PSC_SUSP] && wake_cond
		|=> q.st == swc_pkg::SWC_SUSP)
		else $error("pending wake blocked suspend entry");

	a_suspend_quiet: assert property (
		q.st == swc_pkg::SWC_SUSP |-> s_all_off)
		else $error("clock or processor enabled while suspended");

	a_wake_latch: assert property (
		q.st == swc_pkg::SWC_SUSP && wake_cond |=> q.wlatch)
		else $error("wake condition not held while suspended");

	a_run_gate: assert property (
		q.st == swc_pkg::SWC_SUSP && !q.psc[`SWC_PSC_RUN]
		|=> q.st == swc_pkg::SWC_SUSP)
		else $error("left suspend with the run bit clear");

	a_clock_restart: assert property (s_wake_req |=> s_clock_up)
		else $error("wake did not power an oscillator");

	a_int_delay: assert property (
		q.st == swc_pkg::SWC_START && !q.clk[`SWC_CLK_EXT] && q.cnt == '0
		|=> q.st == swc_pkg::SWC_DELAY
			&& q.cnt == swc_pkg::swc_cnt_t'(`SWC_INT_DLY_CYC))
		else $error("internal clock resume delay not loaded");

	a_ext_delay: assert property (
		q.st == swc_pkg::SWC_START && q.clk[`SWC_CLK_EXT] && osc_stable
		|=> q.st == swc_pkg::SWC_DELAY && q.cnt == $past(ext_dly))
		else $error("external clock resume delay not loaded");

	a_delay_holds: assert property (
		q.st == swc_pkg::SWC_DELAY && q.cnt != '0
		|=> q.st == swc_pkg::SWC_DELAY && !cpu_run)
		else $error("processor released before the delay ran out");

	a_resume_first: assert property (s_delay_done |=> s_first_insn)
		else $error("resume did not hold interrupts for one instruction");

	a_hold_first: assert property (
		q.st == swc_pkg::SWC_FIRST && !insn_done |=> irq_hold)
		else $error("interrupts released before the first instruction");

	a_timer_off: assert property (
		!q.ien[`SWC_IRQ_WAKE] |=> q.wcnt == '0 && !wake_irq)
		else $error("wake timer ran while its interrupt was disabled");

	a_irq_level: assert property (irq == |(q.evst & q.evmask))
		else $error("interrupt output disagrees with enabled status");

	a_status_sticky: assert property (
		q.evst[`SWC_EV_ENTER] && !(do_wr && q.ws && q.awa == `SWC_CLR_OFS)
		|=> q.evst[`SWC_EV_ENTER])
		else $error("status bit dropped without a clear");

	a_write_resp: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response withdrawn before it was taken");

	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before it was taken");

	////////////////////////////////////////////////////////////////////
	assign s_axi_awready = !q.aw;
	assign s_axi_wready = !q.w;
	assign s_axi_bvalid = q.bv;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = !q.rv;
	assign s_axi_rvalid = q.rv;
	assign s_axi_rdata = q.rd;
	assign s_axi_rresp = q.rresp;
	assign cpu_run = q.run;
	assign irq_hold = q.hold;
	assign osc_int_en = q.oi;
	assign osc_ext_en = q.oe;
	assign timer_en = q.ten;
	assign wdt_en = q.ten;
	assign wake_irq = q.wake_pend;
	assign irq = q.irq;
endmodule
`default_nettype wire

// ---- hdl/swc_defines.svh ----
// Register offsets, field positions, reset values and timing counts
// How it works
// - Writing the suspend bit of the control register enters the low-power state
// - In suspend only wake logic, D- receiver and optional wake timer stay alive
// - Suspend stops oscillator, free-running timer and watchdog enables
// - GPIO, wake timer, serial slave or other interrupts, or low D-, end suspend
// - Any enabled pending interrupt wakes; the enable-sense bit is ignored
// - On wake, clocks restart; run resumes after stability and resume delay
// - Resume delay depends on clock source and the external delay setting
// - A wake condition present at entry still suspends, then wakes after delay
// - Firmware sets the run bit; resume happens only while run is set
// - After resume the next instruction runs before any interrupt is serviced
// - Two options: external-only wake, or periodic internal wake timer
// - Wake timer runs while its interrupt is enabled; disabling resets it
// - Internal clock starts within 2 us, execution after further 8 us
// - External clock: wait for stability, then 128 us or 4 ms more
`ifndef SWC_DEFINES_SVH
`define SWC_DEFINES_SVH

`define SWC_PSC_OFS 8'h00
`define SWC_CLK_OFS 8'h04
`define SWC_STAT_OFS 8'h08
`define SWC_CLR_OFS 8'h0c
`define SWC_IEN_OFS 8'h10
`define SWC_IPEND_OFS 8'h14

`define SWC_PSC_RUN 0
`define SWC_PSC_IES 2
`define SWC_PSC_SUSP 3
`define SWC_PSC_RST 8'h01

`define SWC_CLK_EXT 0
`define SWC_CLK_LONG 1

`define SWC_IRQ_GPIO 0
`define SWC_IRQ_WAKE 1
`define SWC_IRQ_SPI 2
`define SWC_IRQ_OTHER 3

`define SWC_EV_ENTER 0
`define SWC_EV_WAKE 1
`define SWC_EV_RESUME 2

`define SWC_CLK_MHZ 100
`define SWC_INT_START_NS 2000
`define SWC_INT_DLY_NS 8000
`define SWC_EXT_SHORT_US 128
`define SWC_EXT_LONG_US 4000
`define SWC_INT_START_CYC (`SWC_INT_START_NS * `SWC_CLK_MHZ / 1000)
`define SWC_INT_DLY_CYC (`SWC_INT_DLY_NS * `SWC_CLK_MHZ / 1000)
`define SWC_EXT_SHORT_CYC (`SWC_EXT_SHORT_US * `SWC_CLK_MHZ)
`define SWC_EXT_LONG_CYC (`SWC_EXT_LONG_US * `SWC_CLK_MHZ)

`endif

// ---- hdl/swc_pkg.sv ----
// Types of the suspend and wake controller
`default_nettype none
package swc_pkg;
	typedef enum logic [2:0] {
		SWC_RUN = 3'b000,
		SWC_SUSP = 3'b001,
		SWC_START = 3'b011,
		SWC_DELAY = 3'b010,
		SWC_FIRST = 3'b110
	} swc_state_e;
	typedef logic [20:0] swc_cnt_t;
endpackage
`default_nettype wire

// ---- sim/swc_cpu_model.sv ----
// Processor and resonator model beside the suspend controller
`default_nettype none
module swc_cpu_model #(
	parameter int STABLE_CYC = 40
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, low
	input wire logic cpu_run, // Processor may execute
	input wire logic osc_ext_en, // Resonator powered
	output logic osc_stable = 1'b0, // Resonator settled
	output logic insn_done = 1'b0 // One instruction retired
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	always @(posedge aclk) begin
		// Settling starts over whenever power is removed
		if (!aresetn || !osc_ext_en)
			cnt <= 0;
		else if (cnt < STABLE_CYC)
			cnt <= cnt + 1;
		osc_stable <= osc_ext_en && cnt == STABLE_CYC;
		insn_done <= aresetn && cpu_run && !insn_done;
	end
endmodule
`default_nettype wire

// ---- sim/test_swc_top.sv ----
// Self-checking bench of the suspend and wake controller
`include "swc_defines.svh"
`default_nettype none
module test_swc_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [3:0] ien;
		logic [1:0] cfg;
		logic pre, g, s, k, w;
		int lo;
	} swc_row_s;
	// Wake enables, clock mode, sources, expected wake, least delay
	swc_row_s rows[7] = '{'{1, 0, 0, 1, 0, 1, 1, 800},
		'{4, 0, 0, 0, 1, 1, 1, 800}, '{0, 0, 0, 0, 0, 0, 1, 800},
		'{2, 0, 0, 0, 0, 1, 1, 800}, '{0, 0, 0, 1, 0, 1, 0, 0},
		'{1, 1, 1, 1, 0, 1, 1, 140}, '{1, 3, 0, 1, 0, 1, 1, 440}};
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic kbd = 1'b1, gpio = 1'b0, spi = 1'b0, oth = 1'b0;
	logic [3:0] wstrb = 4'hf;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd_q;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, cpu_run, irq_hold;
	logic oie, oee, ten, wen, wirq, irq, stable, done;
	int miscompares = 0, n_checks = 0, n;
	swc_top #(.WAKE_PERIOD(300), .EXT_SHORT(100), .EXT_LONG(400))
		swc_top_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .kbd_serial_data(kbd),
		.gpio_irq(gpio), .spi_irq(spi), .other_irq(oth), .osc_stable(stable),
		.insn_done(done), .cpu_run(cpu_run), .irq_hold(irq_hold),
		.osc_int_en(oie), .osc_ext_en(oee), .timer_en(ten), .wdt_en(wen),
		.wake_irq(wirq), .irq(irq));
	swc_cpu_model #(.STABLE_CYC(40)) swc_cpu_model_inst (.aclk(aclk),
		.aresetn(aresetn), .cpu_run(cpu_run), .osc_ext_en(oee),
		.osc_stable(stable), .insn_done(done));
	always #5 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask
	task automatic chkn(input string s, input int lo, g);
		n_checks++;
		if (g < lo) begin
			miscompares++;
			$display("unexpected %s: expected %0d or more, seen %0d", s, lo, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'h3};
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			rd_q = rdata;
		end while (!rvalid);
		rready <= 1'b0;
	endtask
	task automatic wait_run;
		n = 0;
		while (!cpu_run && n < 3000) begin
			@(posedge aclk);
			n++;
		end
	endtask
	task automatic results;
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		#500000;
		miscompares++;
		results();
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`SWC_PSC_OFS);
		chk("control", 32'h1, rd_q);
		chk("clocks", 4'hb, {oie, oee, ten, wen});
		foreach (rows[i]) begin
			wr(`SWC_CLK_OFS, {30'h0, rows[i].cfg});
			wr(`SWC_IEN_OFS, {28'h0, rows[i].ien});
			{gpio, spi, kbd} <= rows[i].pre ?
				{rows[i].g, rows[i].s, 1'b1} : 3'h1;
			wr(`SWC_PSC_OFS, 32'h9);
			@(posedge aclk);
			chk("run", 0, cpu_run);
			if (!rows[i].pre) chk("clocks", 0, {oie, oee, ten, wen});
			{gpio, spi, kbd} <= {rows[i].g, rows[i].s, rows[i].k};
			wait_run();
			chk("woke", rows[i].w, cpu_run);
			if (rows[i].w) begin
				chkn("delay", rows[i].lo, n);
				chk("hold", 1, irq_hold);
				chk("wake irq", rows[i].ien[1], wirq);
				repeat (4) @(posedge aclk);
				chk("hold", 0, irq_hold);
				chk("timers", 2'h3, {ten, wen});
				chk("osc", {!rows[i].cfg[0], rows[i].cfg[0]}, {oie, oee});
			end
			{gpio, spi, kbd} <= {2'h0, cpu_run};
			wait_run();
			@(posedge aclk);
			kbd <= 1'b1;
			$display("row %0d done", i);
		end
		rd(`SWC_STAT_OFS);
		chk("resumed", 1, rd_q[`SWC_EV_RESUME]);
		wr(`SWC_CLR_OFS, 32'hffffffff);
		rd(`SWC_STAT_OFS);
		chk("status", 0, rd_q);
		chk("irq", 0, irq);
		rd(8'h3c);
		chk("rresp", 2'h2, rresp);
		$display("register test done");
		wr(`SWC_IEN_OFS, 32'h78);
		oth <= 1'b1;
		wr(`SWC_PSC_OFS, 32'h9);
		@(posedge aclk);
		wait_run();
		chk("woke", 1, cpu_run);
		chk("irq", 1, irq);
		oth <= 1'b0;
		rd(`SWC_STAT_OFS);
		chk("status", 32'h7, rd_q);
		wr(`SWC_CLR_OFS, 32'h7);
		chk("bresp", 0, bresp);
		chk("irq", 0, irq);
		$display("interrupt test done");
		kbd <= 1'b0;
		wr(`SWC_PSC_OFS, 32'h8);
		@(posedge aclk);
		wait_run();
		chk("run", 0, cpu_run);
		$display("run bit test done");
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("run", 0, cpu_run);
		@(posedge aclk);
		chk("run", 1, cpu_run);
		rd(`SWC_PSC_OFS);
		chk("control", 32'h1, rd_q);
		$display("reset test done");
		results();
	end
endmodule
`default_nettype wire
